// [spg_pkg.sv]
// Constants, register map and carrier types of the strobe pulse generator.
// Assumes a single 200 MHz clock shared by the bus and the strobe logic.
`default_nettype none

package spg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS       = 500;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int START_LAT_NS  = 8200;
    localparam int START_LAT_CYC = (START_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_RISE     = 8'h04;
    localparam logic [7:0] OFS_FALL     = 8'h08;
    localparam logic [7:0] OFS_POSTPONE = 8'h0C;
    localparam logic [7:0] OFS_HALF     = 8'h10;
    localparam logic [7:0] OFS_CMD      = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;

    // ------------------------------------------------------------
    // Host command and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_LAMP_ENABLE = 8'h03;
    localparam int         CMD_OP_LSB      = 0;
    localparam int         CMD_DATA_LSB    = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [25:0] RST_HALF  = 26'h0000002;

    // Acquisition modes; bit 1 marks the external-trigger modes.
    typedef enum logic [1:0] {
        SPG_MODE_NORMAL   = 2'h0,
        SPG_MODE_SOFTWARE = 2'h1,
        SPG_MODE_EXT_SYNC = 2'h2,
        SPG_MODE_EXT_HW   = 2'h3
    } spg_mode_t;

    // Software-visible configuration.
    typedef struct packed {
        logic        lamp;
        spg_mode_t   mode;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] postpone;
        logic [25:0] half;
    } spg_cfg_t;

    // Status word fields.
    typedef struct packed {
        logic lamp;
        logic pending;
        logic active;
        logic periodic;
        logic single;
    } spg_status_t;

endpackage

`default_nettype wire

// [spg_strobe_gen.sv]
// Strobe pulse generator: one-shot strobe timed from each integration start
// and a free-running 50 percent periodic strobe, with an AHB-Lite register slave.
// Assumes detector_reset_gate and ext_trigger are synchronous to hclk.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none

// How it works
// - One-shot strobe fires once per integration start.
// - Strobe rises after the 16-bit rise delay.
// - Strobe falls after the 16-bit fall delay.
// - High time equals fall minus rise delay.
// - Delays count 500 ns ticks, 0 to 65535.
// - One-shot strobe only while lamp enabled.
// - Start event from detector reset gate rise.
// - External trigger gives start after fixed latency.
// - Software and free-run starts also time strobe.
// - Postpone delay adds 500 ns steps to trigger start.
// - Periodic strobe is programmable 50 percent square.
// - Periodic period from 2 us to 60 s.
// - Periodic strobe free-runs, ignoring starts and triggers.
// - Periodic strobe only while lamp enabled.
// - Command 0x03 data 0/1 sets lamp enable.
module spg_strobe_gen (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Detector and trigger inputs
    input  wire logic        detector_reset_gate,
    input  wire logic        ext_trigger,
    // Strobe outputs
    output logic             integration_start_event,
    output logic             single_strobe,
    output logic             periodic_strobe,
    output logic             lamp_enable
);

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    spg_pkg::spg_cfg_t    cfg_q;
    spg_pkg::spg_status_t stat;
    logic                 wr_pend_q;
    logic [7:0]           wr_addr_q;
    logic [31:0]          rd_data;
    logic [31:0]          hrdata_q;
    logic                 hreadyout_q;
    logic [7:0]           cmd_op;
    logic [15:0]          cmd_data;
    logic                 single_q;
    logic                 periodic_q;
    logic                 active_q;
    logic                 pend_q;
    logic                 ev_q;

    assign cmd_op   = hwdata[spg_pkg::CMD_OP_LSB +: 8];
    assign cmd_data = hwdata[spg_pkg::CMD_DATA_LSB +: 16];
    assign stat     = '{lamp: cfg_q.lamp, pending: pend_q, active: active_q,
                        periodic: periodic_q, single: single_q};

    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        rd_data = 32'h00000000;
        unique case (haddr)
            spg_pkg::OFS_MODE:     rd_data = {30'h00000000, cfg_q.mode};
            spg_pkg::OFS_RISE:     rd_data = {16'h0000, cfg_q.rise};
            spg_pkg::OFS_FALL:     rd_data = {16'h0000, cfg_q.fall};
            spg_pkg::OFS_POSTPONE: rd_data = {16'h0000, cfg_q.postpone};
            spg_pkg::OFS_HALF:     rd_data = {6'h00, cfg_q.half};
            spg_pkg::OFS_CMD:      rd_data = {31'h00000000, cfg_q.lamp};
            spg_pkg::OFS_STATUS:   rd_data = {27'h0000000, stat};
            default:               rd_data = 32'h00000000;
        endcase
    end

    // Address phase: read data is fetched here so the slave never waits.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            if (hready)
            begin
                wr_pend_q <= hsel && htrans[1] && hwrite;
                if (hsel && htrans[1])
                begin
                    wr_addr_q <= haddr;
                    hrdata_q  <= hwrite ? 32'h00000000 : rd_data;
                end
            end
        end
    end

    // Data phase writes. Illegal mode codes leave the mode unchanged.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q.lamp     <= 1'b0;
            cfg_q.mode     <= spg_pkg::SPG_MODE_NORMAL;
            cfg_q.rise     <= spg_pkg::RST_DELAY;
            cfg_q.fall     <= spg_pkg::RST_DELAY;
            cfg_q.postpone <= spg_pkg::RST_DELAY;
            cfg_q.half     <= spg_pkg::RST_HALF;
        end
        else if (wr_pend_q)
        begin
            unique case (wr_addr_q)
                spg_pkg::OFS_MODE:
                    if (hwdata[31:2] == 30'h00000000)
                        cfg_q.mode <= spg_pkg::spg_mode_t'(hwdata[1:0]);
                spg_pkg::OFS_RISE:     cfg_q.rise     <= hwdata[15:0];
                spg_pkg::OFS_FALL:     cfg_q.fall     <= hwdata[15:0];
                spg_pkg::OFS_POSTPONE: cfg_q.postpone <= hwdata[15:0];
                spg_pkg::OFS_HALF:     cfg_q.half     <= hwdata[25:0];
                spg_pkg::OFS_CMD:
                    if (cmd_op == spg_pkg::CMD_LAMP_ENABLE && cmd_data[15:1] == 15'h0000)
                        cfg_q.lamp <= cmd_data[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Integration start event
    // ------------------------------------------------------------
    logic        gate_prev_q;
    logic        trig_prev_q;
    logic [23:0] post_cnt_q;
    logic        gate_rise;
    logic        trig_rise;

    assign gate_rise = detector_reset_gate && !gate_prev_q;
    assign trig_rise = ext_trigger && !trig_prev_q;

    // External modes start from the trigger after the fixed latency plus the
    // postpone delay; further triggers are ignored while one is pending.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gate_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
            pend_q      <= 1'b0;
            post_cnt_q  <= 24'h000000;
            ev_q        <= 1'b0;
        end
        else
        begin
            gate_prev_q <= detector_reset_gate;
            trig_prev_q <= ext_trigger;
            ev_q        <= 1'b0;
            if (pend_q)
            begin
                post_cnt_q <= post_cnt_q - 24'h000001;
                if (post_cnt_q == 24'h000001)
                begin
                    pend_q <= 1'b0;
                    ev_q   <= 1'b1;
                end
            end
            else if (cfg_q.mode[1] && trig_rise)
            begin
                pend_q     <= 1'b1;
                post_cnt_q <= 24'(spg_pkg::START_LAT_CYC)
                            + 24'(cfg_q.postpone) * 24'(spg_pkg::TICK_CYC);
            end
            if (!cfg_q.mode[1] && gate_rise)
                ev_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // One-shot strobe
    // ------------------------------------------------------------
    logic [6:0]  os_pre_q;
    logic [16:0] os_tick_q;
    logic [15:0] rise_q;
    logic [15:0] fall_q;

    // Delays are latched at each start so a rewrite cannot tear a pulse.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_q  <= 1'b0;
            os_pre_q  <= 7'h00;
            os_tick_q <= 17'h00000;
            rise_q    <= 16'h0000;
            fall_q    <= 16'h0000;
        end
        else if (ev_q)
        begin
            active_q  <= 1'b1;
            os_pre_q  <= 7'h00;
            os_tick_q <= 17'h00000;
            rise_q    <= cfg_q.rise;
            fall_q    <= cfg_q.fall;
        end
        else if (active_q)
        begin
            if (os_tick_q >= {1'b0, fall_q})
                active_q <= 1'b0;
            if (os_pre_q == 7'(spg_pkg::TICK_CYC - 1))
            begin
                os_pre_q  <= 7'h00;
                os_tick_q <= os_tick_q + 17'h00001;
            end
            else
                os_pre_q <= os_pre_q + 7'h01;
        end
    end

    // High between rise and fall ticks only; an empty window gives no pulse.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            single_q <= 1'b0;
        else
            single_q <= cfg_q.lamp && active_q
                     && os_tick_q >= {1'b0, rise_q}
                     && os_tick_q < {1'b0, fall_q};
    end

    // ------------------------------------------------------------
    // Periodic strobe
    // ------------------------------------------------------------
    logic [6:0]  fr_pre_q;
    logic        tick_q;
    logic [25:0] half_cnt_q;
    logic [25:0] half_lim;

    // A zero half period would stall the wave, so it behaves as one tick.
    assign half_lim = (cfg_q.half == 26'h0000000) ? 26'h0000000
                                                  : cfg_q.half - 26'h0000001;

    // Free 500 ns tick, unrelated to starts and triggers.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fr_pre_q <= 7'h00;
            tick_q   <= 1'b0;
        end
        else
        begin
            tick_q   <= (fr_pre_q == 7'(spg_pkg::TICK_CYC - 1));
            fr_pre_q <= (fr_pre_q == 7'(spg_pkg::TICK_CYC - 1)) ? 7'h00 : fr_pre_q + 7'h01;
        end
    end

    // Toggles every half period; the tick phase is not realigned on enable.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            periodic_q <= 1'b0;
            half_cnt_q <= 26'h0000000;
        end
        else if (!cfg_q.lamp)
        begin
            periodic_q <= 1'b0;
            half_cnt_q <= 26'h0000000;
        end
        else if (tick_q)
        begin
            if (half_cnt_q >= half_lim)
            begin
                periodic_q <= !periodic_q;
                half_cnt_q <= 26'h0000000;
            end
            else
                half_cnt_q <= half_cnt_q + 26'h0000001;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout               = hreadyout_q;
    assign hresp                   = 1'b0 & hreadyout_q;
    assign hrdata                  = hrdata_q;
    assign integration_start_event = ev_q;
    assign single_strobe           = single_q;
    assign periodic_strobe         = periodic_q;
    assign lamp_enable             = cfg_q.lamp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_lamp_gates_single: assert property (!cfg_q.lamp |=> !single_q)
        else $error("single strobe high while lamp off");
    a_lamp_gates_periodic: assert property (!cfg_q.lamp |=> !periodic_q)
        else $error("periodic strobe high while lamp off");
    a_gate_starts: assert property (!cfg_q.mode[1] && gate_rise |=> ev_q)
        else $error("gate rise gave no start event");
    a_trig_loads_delay: assert property (cfg_q.mode[1] && trig_rise && !pend_q
        |=> post_cnt_q == 24'(spg_pkg::START_LAT_CYC)
            + 24'($past(cfg_q.postpone)) * 24'(spg_pkg::TICK_CYC))
        else $error("postpone count loaded wrong");
    a_pending_fires: assert property (pend_q && post_cnt_q == 24'h000001 |=> ev_q && !pend_q)
        else $error("pending start did not fire");
    a_rise_zero: assert property (ev_q && cfg_q.lamp && cfg_q.rise == 16'h0000
        && cfg_q.fall != 16'h0000 && $stable(cfg_q.lamp) ##1 cfg_q.lamp |=> single_q)
        else $error("zero rise delay did not raise strobe");
    a_empty_window: assert property (ev_q && cfg_q.fall <= cfg_q.rise
        |=> !single_q [*8])
        else $error("pulse with fall not after rise");
    a_fall_ends_shot: assert property ($fell(single_q) && $past(cfg_q.lamp)
        && !$past(ev_q) |-> !active_q || ev_q)
        else $error("one-shot still active after fall");
    a_periodic_toggle: assert property (cfg_q.lamp && tick_q && half_cnt_q >= half_lim
        ##1 cfg_q.lamp |-> periodic_q != $past(periodic_q))
        else $error("periodic strobe missed a toggle");
    a_cmd_lamp: assert property (wr_pend_q && wr_addr_q == spg_pkg::OFS_CMD
        && cmd_op == spg_pkg::CMD_LAMP_ENABLE && cmd_data[15:1] == 15'h0000
        |=> cfg_q.lamp == $past(cmd_data[0]))
        else $error("lamp command not applied");

    c_single_pulse: cover property ($rose(single_q) ##[1:1000] $fell(single_q));
    c_ext_start: cover property (pend_q ##1 ev_q);
    c_periodic_run: cover property ($rose(periodic_q) ##[1:1000] $fell(periodic_q));

endmodule

`default_nettype wire

// [spg_lamp_model.sv]
// Behavioural model of the lamp-side instrument: it fires the trigger and times strobes.
// Assumes every input is synchronous to hclk.
`default_nettype none

module spg_lamp_model (
    // Clock
    input  wire logic        hclk,
    // Bench control
    input  wire logic        fire,
    input  wire logic        watch,
    // Device outputs
    input  wire logic        start_ev,
    input  wire logic        single_strobe,
    input  wire logic        periodic_strobe,
    // Trigger into the device
    output logic             ext_trigger,
    // Timing results
    output logic             res_v,
    output logic [31:0]      res_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] since_q = 32'h0;
    logic [31:0] wid_q = 32'h0;
    logic [31:0] ph_q = 32'h0;
    logic [31:0] lat_q = 32'h0;
    logic [3:0]  hold_q = 4'h0;
    logic        lat_on_q = 1'b0;
    logic        s_prev_q = 1'b0;
    logic        p_prev_q = 1'b0;

    // Outputs start low so the device never sees a spurious trigger edge.
    initial
    begin
        ext_trigger = 1'b0;
        res_v = 1'b0;
        res_n = 32'h0;
    end

    // The trigger is a clean pulse that stays high ten cycles past the last fire, then is driven low again.
    always @(posedge hclk)
    begin
        if (fire)
        begin
            ext_trigger <= 1'b1;
            hold_q      <= 4'h9;
        end
        else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
        else
            ext_trigger <= 1'b0;
    end

    // One result a cycle: trigger latency, rise delay, high time, periodic phase.
    always @(posedge hclk)
    begin
        res_v    <= 1'b0;
        s_prev_q <= single_strobe;
        p_prev_q <= periodic_strobe;
        since_q  <= start_ev ? 32'h0 : since_q + 32'h1;
        wid_q    <= single_strobe ? wid_q + 32'h1 : 32'h0;
        ph_q     <= (periodic_strobe != p_prev_q) ? 32'h1 : ph_q + 32'h1;
        lat_q    <= (fire && !lat_on_q) ? 32'h0 : lat_q + 32'h1; // From the trigger's rise.
        if (fire)
            lat_on_q <= 1'b1;
        else if (start_ev && lat_on_q)
        begin
            res_v    <= 1'b1;
            res_n    <= lat_q;
            lat_on_q <= 1'b0;
        end
        else if (single_strobe && !s_prev_q)
        begin
            res_v <= 1'b1;
            res_n <= since_q;
        end
        else if (!single_strobe && s_prev_q)
        begin
            res_v <= 1'b1;
            res_n <= wid_q;
        end
        else if (watch && periodic_strobe != p_prev_q)
        begin
            res_v <= 1'b1;
            res_n <= ph_q;
        end
    end
endmodule

`default_nettype wire

// [spg_strobe_gen_test.sv]
// Self-checking bench: registers over AHB-Lite, one-shot timing in all modes,
// lamp gating and the periodic strobe. Assumes the design and model compile first.
`default_nettype none

module spg_strobe_gen_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        gate = 1'b0;
    logic        fire = 1'b0;
    logic        watch = 1'b0;
    logic        dph_rd = 1'b0;
    logic        hready, hresp, start_ev, single, periodic, lamp, ext_trig, res_v;
    logic [31:0] hrdata, res_n;
    logic [31:0] bq[$];
    logic [31:0] mq[$];
    int          num_errors = 0;
    int          comparisons = 0;
    logic [7:0]  seed = 8'h12;

    // The clock toggles every half period of 2.5 ns.
    always #2.5 hclk = ~hclk;

    spg_strobe_gen spg_strobe_gen_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .detector_reset_gate(gate), .ext_trigger(ext_trig),
        .integration_start_event(start_ev), .single_strobe(single),
        .periodic_strobe(periodic), .lamp_enable(lamp));

    spg_lamp_model spg_lamp_model_inst (
        .hclk(hclk), .fire(fire), .watch(watch), .start_ev(start_ev),
        .single_strobe(single), .periodic_strobe(periodic), .ext_trigger(ext_trig),
        .res_v(res_v), .res_n(res_n));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A slack of a few cycles is allowed since delays are counted in 100-cycle ticks.
    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input int tol);
        logic ok;
        ok = 1'b0;
        for (int d = -tol; d <= tol; d++)
            if (got === exp + 32'(d))
                ok = 1'b1;
        comparisons++;
        if (!ok)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                num_errors++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    // One single transfer: address phase until ready, then the data phase.
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bq.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic drain(input int limit);
        int n;
        n = 0;
        while (mq.size() != 0)
        begin
            n++;
            if (n > limit)
            begin
                num_errors++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    task automatic pulse(input logic trig);
        if (trig)
            fire <= 1'b1;
        else
            gate <= 1'b1;
        tick(3);
        fire <= 1'b0;
        gate <= 1'b0;
        tick(1);
    endtask

    // Results meet the oldest note; an unannounced strobe result is a mismatch.
    always @(posedge hclk)
    begin
        dph_rd <= hsel && htrans[1] && !hwrite && hready;
        if (dph_rd && hready === 1'b1)
        begin
            compare(hrdata, bq.pop_front(), 0);
            compare(32'(hresp), 32'h0, 0);
        end
        if (res_v === 1'b1)
            compare(res_n, (mq.size() != 0) ? mq.pop_front() : 32'hFFFFFFFF, 2);
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        logic [15:0] r;
        logic [15:0] f;
        tick(4);
        hresetn <= 1'b1;
        tick(2);
        // Reset values of every register and of one unmapped word.
        for (int i = 0; i < 8; i++)
            rd(8'(4 * i), (i == 4) ? 32'h2 : 32'h0);
        // A bad data value and a foreign opcode leave the lamp off.
        bus(spg_pkg::OFS_CMD, 1'b1, 32'h0000_0203);
        bus(spg_pkg::OFS_CMD, 1'b1, 32'h0000_0104);
        rd(spg_pkg::OFS_CMD, 32'h0);
        compare(32'(lamp), 32'h0, 0);
        // With the lamp off a start gives no strobe and the square wave stays low.
        bus(spg_pkg::OFS_HALF, 1'b1, 32'h3);
        bus(spg_pkg::OFS_RISE, 1'b1, 32'h1);
        bus(spg_pkg::OFS_FALL, 1'b1, 32'h2);
        watch <= 1'b1;
        pulse(1'b0);
        tick(3 * spg_pkg::TICK_CYC);
        rd(spg_pkg::OFS_STATUS, 32'h0);
        watch <= 1'b0;
        bus(spg_pkg::OFS_CMD, 1'b1, 32'h0000_0103);
        rd(spg_pkg::OFS_CMD, 32'h1);
        compare(32'(lamp), 32'h1, 0);
        // Both phases of the square wave last the programmed half period. The
        // one-shot is timed apart, so its results cannot interleave with toggles.
        tick(700);
        repeat (4) mq.push_back(32'(3 * spg_pkg::TICK_CYC));
        watch <= 1'b1;
        drain(2000);
        watch <= 1'b0;
        // A zero rise delay raises the strobe right after the start.
        bus(spg_pkg::OFS_RISE, 1'b1, 32'h0);
        mq.push_back(32'h2);
        mq.push_back(32'(2 * spg_pkg::TICK_CYC));
        pulse(1'b0);
        drain(2000);
        bus(spg_pkg::OFS_POSTPONE, 1'b1, 32'h1);
        // Every mode once with random delays, then fall equal to rise.
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            r = 16'(seed[1:0]);
            f = (i == 4) ? r : r + 16'(seed[3:2]) + 16'h1;
            bus(spg_pkg::OFS_MODE, 1'b1, 32'(i % 4));
            bus(spg_pkg::OFS_RISE, 1'b1, 32'(r));
            bus(spg_pkg::OFS_FALL, 1'b1, 32'(f));
            if (i % 4 >= 2)
                mq.push_back(32'(spg_pkg::START_LAT_CYC + spg_pkg::TICK_CYC + 1));
            if (f > r)
            begin
                mq.push_back(32'(2 + r * spg_pkg::TICK_CYC));
                mq.push_back(32'((f - r) * spg_pkg::TICK_CYC));
            end
            pulse(1'b0);
            if (i % 4 >= 2)
                pulse(1'b1);
            drain(4000);
            tick(int'(f) * spg_pkg::TICK_CYC + 200);
        end
        if (mq.size() != 0 || bq.size() != 0)
            num_errors++;
        conclude();
    end
endmodule

`default_nettype wire
